// ---- rtl/usbps_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Device role lets PHY suspend only when function stopped or host suspended bus.
// - Device role clears PHY suspend by itself when host resume signalling arrives.
// - Host role enters PHY suspend only by software, port suspended or nothing attached.
// - Wakeup with port suspended, PHY awake: port-change interrupt, PHY suspend not set.
// - Wakeup with PHY suspended, power-down and gate clear: remote-wakeup interrupt.
// - After that wakeup, power-down bits and clock gate are cleared, never retained.
// - During receive overrun token answers stop; they resume once overrun clears.
module usbps_ctrl (
    // Clock and reset
    input  logic                      core_clk_i,
    input  logic                      rst_i,
    // Register bus
    input  usbps_pkg::usbps_axil_req_t axil_req_i,
    output usbps_pkg::usbps_axil_rsp_t axil_rsp_o,
    // Link and PHY side
    input  usbps_pkg::usbps_link_in_t  link_i,
    output usbps_pkg::usbps_phy_out_t  phy_o,
    // Interrupt
    output logic                      irq_o
);
    import usbps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel state
    usbps_bus_st_t     wst_q, wst_d;
    logic              aw_got_q, aw_got_d;
    logic              w_got_q, w_got_d;
    logic [AXI_AW-1:0] waddr_q, waddr_d;
    logic [31:0]       wdata_q, wdata_d;
    logic [3:0]        wstrb_q, wstrb_d;
    logic              awready_q, awready_d;
    logic              wready_q, wready_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              wr_en;

    // Read channel state
    usbps_bus_st_t     rst_q, rst_d;
    logic              arready_q, arready_d;
    logic              rvalid_q, rvalid_d;
    logic [31:0]       rdata_q, rdata_d;
    logic [1:0]        rresp_q, rresp_d;
    logic [31:0]       rd_mux;
    logic              rd_ok;

    // Core state
    logic [2:0]        ctrl_q, ctrl_d;
    logic              port_suspend_q, port_suspend_d;
    logic              phy_low_power_suspend_q, phy_low_power_suspend_d;
    logic              fres_q, fres_d;
    logic [PWD_W-1:0]  pwd_q, pwd_d;
    logic              gate_q, gate_d;
    logic [NSTS-1:0]   mask_q, mask_d;
    logic              irq_q, irq_d;
    logic              token_q, token_d;
    logic              ovr_prev_q;
    logic [NSTS-1:0]   sts_q;
    logic [NSTS-1:0]   sts_set;
    logic [NSTS-1:0]   sts_clr;

    // Decoded helpers
    logic              wr_lane;
    logic [7:0]        wd;
    logic              wr_ctrl, wr_port, wr_pwd, wr_gate, wr_sts, wr_mask;
    logic              dev_role;
    logic              phy_low_power_suspend_allowed;
    logic              port_port_suspend_now;
    logic              rw_pci;
    logic              rw_rwu;

    function automatic logic addr_ok(input logic [AXI_AW-1:0] a);
        logic ok;
        ok = 1'b0;
        if (a == OFS_CTRL || a == OFS_PORT || a == OFS_PWD || a == OFS_GATE)
            ok = 1'b1;
        else if (a == OFS_STS || a == OFS_MASK || a == OFS_LINK)
            ok = 1'b1;
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order, one write at a time
    always_comb
    begin
        wst_d    = wst_q;
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        waddr_d  = waddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        wr_en    = 1'b0;
        if (axil_req_i.awvalid && awready_q)
        begin
            aw_got_d = 1'b1;
            waddr_d  = axil_req_i.awaddr;
        end
        if (axil_req_i.wvalid && wready_q)
        begin
            w_got_d = 1'b1;
            wdata_d = axil_req_i.wdata;
            wstrb_d = axil_req_i.wstrb;
        end
        case (wst_q)
            BUS_IDLE:
            begin
                if (aw_got_q && w_got_q)
                begin
                    wr_en    = addr_ok(waddr_q);
                    aw_got_d = 1'b0;
                    w_got_d  = 1'b0;
                    bvalid_d = 1'b1;
                    bresp_d  = addr_ok(waddr_q) ? RESP_OKAY : RESP_SLVERR;
                    wst_d    = BUS_RESP;
                end
            end
            BUS_RESP:
            begin
                if (axil_req_i.bready)
                begin
                    bvalid_d = 1'b0;
                    wst_d    = BUS_IDLE;
                end
            end
            default:
            begin
                wst_d = BUS_IDLE;
            end
        endcase
        awready_d = !aw_got_d && (wst_d == BUS_IDLE);
        wready_d  = !w_got_d && (wst_d == BUS_IDLE);
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wst_q     <= BUS_IDLE;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            wst_q     <= wst_d;
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: data registered at the address handshake
    always_comb
    begin
        rd_ok  = 1'b1;
        rd_mux = '0;
        if (axil_req_i.araddr == OFS_CTRL)
            rd_mux[2:0] = ctrl_q;
        else if (axil_req_i.araddr == OFS_PORT)
            rd_mux[2:0] = {fres_q, phy_low_power_suspend_q, port_suspend_q};
        else if (axil_req_i.araddr == OFS_PWD)
            rd_mux[PWD_W-1:0] = pwd_q;
        else if (axil_req_i.araddr == OFS_GATE)
            rd_mux[GATE_BIT] = gate_q;
        else if (axil_req_i.araddr == OFS_STS)
            rd_mux[NSTS-1:0] = sts_q;
        else if (axil_req_i.araddr == OFS_MASK)
            rd_mux[NSTS-1:0] = mask_q;
        else if (axil_req_i.araddr == OFS_LINK)
            rd_mux[3:0] = {token_q, link_i.rx_overrun, link_i.dev_attached,
                           link_i.host_suspend};
        else
            rd_ok = 1'b0;
    end

    always_comb
    begin
        rst_d     = rst_q;
        arready_d = arready_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        case (rst_q)
            BUS_IDLE:
            begin
                arready_d = 1'b1;
                if (axil_req_i.arvalid && arready_q)
                begin
                    rvalid_d  = 1'b1;
                    rdata_d   = rd_mux;
                    rresp_d   = rd_ok ? RESP_OKAY : RESP_SLVERR;
                    arready_d = 1'b0;
                    rst_d     = BUS_RESP;
                end
            end
            BUS_RESP:
            begin
                if (axil_req_i.rready)
                begin
                    rvalid_d  = 1'b0;
                    arready_d = 1'b1;
                    rst_d     = BUS_IDLE;
                end
            end
            default:
            begin
                rst_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rst_q     <= BUS_IDLE;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end
        else
        begin
            rst_q     <= rst_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Suspend and resume control
    // All fields sit in byte lane 0, so only that strobe matters
    assign wr_lane = wr_en && wstrb_q[0];
    assign wd      = wdata_q[7:0];

    always_comb
    begin
        wr_ctrl = 1'b0;
        wr_port = 1'b0;
        wr_pwd  = 1'b0;
        wr_gate = 1'b0;
        wr_sts  = 1'b0;
        wr_mask = 1'b0;
        if (wr_lane && waddr_q == OFS_CTRL)
            wr_ctrl = 1'b1;
        else if (wr_lane && waddr_q == OFS_PORT)
            wr_port = 1'b1;
        else if (wr_lane && waddr_q == OFS_PWD)
            wr_pwd = 1'b1;
        else if (wr_lane && waddr_q == OFS_GATE)
            wr_gate = 1'b1;
        else if (wr_lane && waddr_q == OFS_STS)
            wr_sts = 1'b1;
        else if (wr_lane && waddr_q == OFS_MASK)
            wr_mask = 1'b1;
    end

    assign dev_role = ctrl_q[CTRL_DEV_BIT];
    // The port must still be suspended once the same write has landed
    assign port_port_suspend_now = wr_port ? wd[PORT_PORT_SUSPEND_BIT] : port_suspend_q;
    // Device: function stopped or bus suspended; host: port suspended or empty
    assign phy_low_power_suspend_allowed = dev_role ? (!ctrl_q[CTRL_RUN_BIT] || link_i.host_suspend)
                                   : (port_port_suspend_now || !link_i.dev_attached);
    assign rw_pci = link_i.remote_wake && port_suspend_q && !phy_low_power_suspend_q;
    assign rw_rwu = link_i.remote_wake && phy_low_power_suspend_q && pwd_q == PWD_RST && !gate_q;

    always_comb
    begin
        ctrl_d = wr_ctrl ? wd[2:0] : ctrl_q;
        mask_d = wr_mask ? wd[NSTS-1:0] : mask_q;
        port_suspend_d = wr_port ? wd[PORT_PORT_SUSPEND_BIT] : port_suspend_q;
        pwd_d  = wr_pwd ? wd[PWD_W-1:0] : pwd_q;
        gate_d = wr_gate ? wd[GATE_BIT] : gate_q;
        phy_low_power_suspend_d = phy_low_power_suspend_q;
        fres_d = fres_q;
        if (wr_port)
        begin
            // Only software raises the suspend bit, and only when it is allowed
            if (!wd[PORT_PHY_LOW_POWER_SUSPEND_BIT])
                phy_low_power_suspend_d = 1'b0;
            else if (phy_low_power_suspend_allowed && !rw_pci)
                phy_low_power_suspend_d = 1'b1;
            fres_d = wd[PORT_FRES_BIT];
        end
        if (dev_role && link_i.host_resume)
        begin
            phy_low_power_suspend_d = 1'b0;
            port_suspend_d = 1'b0;
            pwd_d  = PWD_RST;
            gate_d = 1'b0;
        end
        if (rw_rwu)
        begin
            // Wake the PHY instead of leaving it half powered down
            phy_low_power_suspend_d = 1'b0;
            pwd_d  = PWD_RST;
            gate_d = 1'b0;
        end
        // A forced resume against a suspended PHY would be lost
        if (phy_low_power_suspend_d)
            fres_d = 1'b0;
        sts_set              = '0;
        sts_set[STS_PCI_BIT] = rw_pci;
        sts_set[STS_RWU_BIT] = rw_rwu;
        sts_set[STS_OVR_BIT] = link_i.rx_overrun && !ovr_prev_q;
        sts_clr = wr_sts ? wd[NSTS-1:0] : '0;
        token_d = !link_i.rx_overrun;
        irq_d   = |(sts_q & mask_q);
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_q     <= CTRL_RST;
            mask_q     <= MASK_RST;
            port_suspend_q     <= 1'b0;
            phy_low_power_suspend_q     <= 1'b0;
            fres_q     <= 1'b0;
            pwd_q      <= PWD_RST;
            gate_q     <= 1'b0;
            irq_q      <= 1'b0;
            token_q    <= 1'b0;
            ovr_prev_q <= 1'b0;
        end
        else
        begin
            ctrl_q     <= ctrl_d;
            mask_q     <= mask_d;
            port_suspend_q     <= port_suspend_d;
            phy_low_power_suspend_q     <= phy_low_power_suspend_d;
            fres_q     <= fres_d;
            pwd_q      <= pwd_d;
            gate_q     <= gate_d;
            irq_q      <= irq_d;
            token_q    <= token_d;
            ovr_prev_q <= link_i.rx_overrun;
        end
    end

    usbps_sticky #(
        .W(NSTS)
    ) u_sts (
        .core_clk_i(core_clk_i),
        .rst_i     (rst_i),
        .set_i     (sts_set),
        .clr_i     (sts_clr),
        .q_o       (sts_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign axil_rsp_o = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
                          bresp: bresp_q, arready: arready_q, rvalid: rvalid_q,
                          rdata: rdata_q, rresp: rresp_q};
    assign phy_o = '{phy_low_power_suspend: phy_low_power_suspend_q, phy_power_down_register: pwd_q,
                     phy_utmi_gate: gate_q, force_resume: fres_q,
                     token_answer_en: token_q,
                     stream_disable: ctrl_q[CTRL_STREAM_DISABLE_BIT]};
    assign irq_o = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_dev_enter_gate: assert property ($rose(phy_low_power_suspend_q) && $past(dev_role)
                                       |-> $past(phy_low_power_suspend_allowed) && $past(wr_port))
        else $error("PHY suspend entered in device role while not allowed");
    a_host_enter_gate: assert property ($rose(phy_low_power_suspend_q) && !$past(dev_role)
                                        |-> $past(wr_port) && $past(phy_low_power_suspend_allowed))
        else $error("PHY suspend entered in host role without software or permission");
    a_resume_clears: assert property (dev_role && link_i.host_resume
                                      |=> !phy_low_power_suspend_q && pwd_q == PWD_RST && !gate_q)
        else $error("Host resume did not clear PHY suspend");
    a_fres_awake: assert property (fres_q |-> !phy_low_power_suspend_q)
        else $error("Forced resume driven while PHY suspended");
    a_pci_no_phy_low_power_suspend: assert property (rw_pci |=> sts_q[STS_PCI_BIT] && !phy_low_power_suspend_q)
        else $error("Port-change wakeup mishandled");
    a_rwu_raise: assert property (rw_rwu |=> sts_q[STS_RWU_BIT]
                                  ##1 (irq_q || !$past(mask_q[STS_RWU_BIT])))
        else $error("Remote-wakeup interrupt not raised");
    a_no_retain: assert property (rw_rwu |=> pwd_q == PWD_RST && !gate_q && !phy_low_power_suspend_q)
        else $error("Power-down or clock gate retained after wakeup");
    a_token_stall: assert property (link_i.rx_overrun |=> !token_q)
        else $error("Token answers not stopped during overrun");
    a_token_resume: assert property ($fell(link_i.rx_overrun) |-> ##1 token_q)
        else $error("Token answers not resumed after overrun");
    a_bvalid_hold: assert property (bvalid_q && !axil_req_i.bready |=> bvalid_q)
        else $error("Write response dropped before bready");

endmodule

// ---- rtl/usbps_sticky.sv ----
`timescale 1ns/1ps
module usbps_sticky #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  logic         core_clk_i,
    input  logic         rst_i,
    // Events and write-one-to-clear
    input  logic [W-1:0] set_i,
    input  logic [W-1:0] clr_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    if (W < 1 || W > 32)
    begin : g_chk
        $error("usbps_sticky: W must be 1 to 32");
    end

    // A set in the cycle of its clear wins, so no event is lost
    always_comb
    begin
        q_d = (q_q & ~clr_i) | set_i;
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            q_q <= '0;
        else
            q_q <= q_d;
    end

    assign q_o = q_q;

endmodule

// ---- shared/usbps_pkg.sv ----
package usbps_pkg;

    localparam int unsigned AXI_AW = 8;
    localparam int unsigned PWD_W  = 8;
    localparam int unsigned NSTS   = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_PORT = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_PWD  = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_GATE = 8'h0c;
    localparam logic [AXI_AW-1:0] OFS_STS  = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_MASK = 8'h14;
    localparam logic [AXI_AW-1:0] OFS_LINK = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned CTRL_DEV_BIT  = 0;
    localparam int unsigned CTRL_RUN_BIT  = 1;
    localparam int unsigned CTRL_STREAM_DISABLE_BIT = 2;
    localparam int unsigned PORT_PORT_SUSPEND_BIT = 0;
    localparam int unsigned PORT_PHY_LOW_POWER_SUSPEND_BIT = 1;
    localparam int unsigned PORT_FRES_BIT = 2;
    localparam int unsigned GATE_BIT      = 0;
    localparam int unsigned STS_PCI_BIT   = 0;
    localparam int unsigned STS_RWU_BIT   = 1;
    localparam int unsigned STS_OVR_BIT   = 2;
    localparam int unsigned LINK_PORT_SUSPEND_BIT = 0;
    localparam int unsigned LINK_ATT_BIT  = 1;
    localparam int unsigned LINK_OVR_BIT  = 2;
    localparam int unsigned LINK_TOK_BIT  = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and bus answers
    localparam logic [2:0]       CTRL_RST    = 3'h1;
    localparam logic [PWD_W-1:0] PWD_RST     = 8'h00;
    localparam logic [NSTS-1:0]  MASK_RST    = 3'h0;
    localparam logic [1:0]       RESP_OKAY   = 2'h0;
    localparam logic [1:0]       RESP_SLVERR = 2'h2;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_RESP = 1'b1
    } usbps_bus_st_t;

    typedef struct packed {
        logic              awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [AXI_AW-1:0] araddr;
        logic              rready;
    } usbps_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } usbps_axil_rsp_t;

    typedef struct packed {
        logic host_suspend;
        logic host_resume;
        logic remote_wake;
        logic dev_attached;
        logic rx_overrun;
    } usbps_link_in_t;

    typedef struct packed {
        logic             phy_low_power_suspend;
        logic [PWD_W-1:0] phy_power_down_register;
        logic             phy_utmi_gate;
        logic             force_resume;
        logic             token_answer_en;
        logic             stream_disable;
    } usbps_phy_out_t;

endpackage

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    import usbps_pkg::*;

    logic            core_clk_i;
    logic            rst_i;
    usbps_axil_req_t rq;
    usbps_axil_rsp_t rs;
    usbps_link_in_t  lk;
    usbps_phy_out_t  po;
    logic            irq_o;
    int              fails;
    int              n_compared;
    logic [31:0]     d;
    logic [1:0]      r;

    usbps_ctrl dut (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .axil_req_i (rq),
        .axil_rsp_o (rs),
        .link_i     (lk),
        .phy_o      (po),
        .irq_o      (irq_o)
    );

    usbps_far_end far (
        .core_clk_i (core_clk_i),
        .link_o     (lk)
    );

    initial
    begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        rq.awvalid <= 1'b1;
        rq.awaddr  <= a;
        rq.wvalid  <= 1'b1;
        rq.wdata   <= v;
        rq.wstrb   <= 4'hf;
        // bready follows bvalid by one edge, so the response has to stand
        do
        begin
            @(posedge core_clk_i);
            if (rs.awready === 1'b1)
                rq.awvalid <= 1'b0;
            if (rs.wready === 1'b1)
                rq.wvalid <= 1'b0;
            if (rs.bvalid === 1'b1 && rq.bready !== 1'b1)
                rq.bready <= 1'b1;
        end
        while (rs.bvalid !== 1'b1 || rq.bready !== 1'b1);
        r = rs.bresp;
        rq.bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge core_clk_i);
        rq.arvalid <= 1'b1;
        rq.araddr  <= a;
        rq.rready  <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            if (rs.arready === 1'b1)
                rq.arvalid <= 1'b0;
        end
        while (rs.rvalid !== 1'b1);
        d = rs.rdata;
        r = rs.rresp;
        rq.rready <= 1'b0;
    endtask

    task rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask

    // Whole PHY side word; a slow read first lets one-edge effects land
    task cp(input usbps_phy_out_t e);
        rd(OFS_CTRL);
        chk({19'h0, po}, {19'h0, e});
    endtask

    task give_verdict();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        fails++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rq = '0;
        rst_i = 1'b1;
        fails = 0;
        n_compared = 0;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rc(OFS_CTRL, 32'h1);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        rc(OFS_PORT, 32'h0);
        rc(OFS_GATE, 32'h0);
        rc(OFS_STS, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        rc(OFS_PWD, 32'h0);
        rc(OFS_MASK, 32'h0);
        rc(OFS_LINK, 32'h8);
        rc(8'h1c, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h1c, 32'h1);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(OFS_LINK, 32'hf);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        rc(OFS_LINK, 32'h8);
        // Device running, bus awake: suspend request must be refused
        wr(OFS_CTRL, 32'h3);
        wr(OFS_PORT, 32'h3);
        rc(OFS_PORT, 32'h1);
        far.level(1'b1, 1'b0, 1'b0);
        wr(OFS_PORT, 32'h3);
        rc(OFS_PORT, 32'h3);
        wr(OFS_PWD, 32'hff);
        wr(OFS_GATE, 32'h1);
        cp({1'b1, 8'hff, 1'b1, 3'b010});
        wr(OFS_PORT, 32'h7);
        rc(OFS_PORT, 32'h3);
        far.resume();
        rc(OFS_PORT, 32'h0);
        cp({1'b0, 8'h00, 1'b0, 3'b010});
        wr(OFS_PORT, 32'h4);
        cp({1'b0, 8'h00, 1'b0, 3'b110});
        // Wakeup with only the port suspended
        wr(OFS_MASK, 32'h7);
        far.level(1'b0, 1'b0, 1'b0);
        wr(OFS_PORT, 32'h1);
        far.wake();
        rc(OFS_STS, 32'h1);
        rc(OFS_PORT, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wr(OFS_STS, 32'h1);
        rc(OFS_STS, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        // Wakeup with PHY suspended; its status bit is masked here
        wr(OFS_CTRL, 32'h1);
        wr(OFS_PORT, 32'h3);
        wr(OFS_MASK, 32'h5);
        far.wake();
        rc(OFS_STS, 32'h2);
        chk({31'h0, irq_o}, 32'h0);
        cp({1'b0, 8'h00, 1'b0, 3'b010});
        wr(OFS_STS, 32'h2);
        // Host role
        wr(OFS_CTRL, 32'h0);
        far.level(1'b0, 1'b1, 1'b0);
        wr(OFS_PORT, 32'h2);
        rc(OFS_PORT, 32'h0);
        wr(OFS_PORT, 32'h3);
        rc(OFS_PORT, 32'h3);
        far.resume();
        rc(OFS_PORT, 32'h3);
        wr(OFS_PORT, 32'h0);
        far.level(1'b0, 1'b0, 1'b0);
        wr(OFS_PORT, 32'h2);
        rc(OFS_PORT, 32'h2);
        wr(OFS_PORT, 32'h0);
        // Overrun silences token answers until it clears
        wr(OFS_CTRL, 32'h5);
        wr(OFS_MASK, 32'h4);
        far.level(1'b0, 1'b0, 1'b1);
        rc(OFS_LINK, 32'h4);
        rc(OFS_STS, 32'h4);
        chk({31'h0, irq_o}, 32'h1);
        cp({1'b0, 8'h00, 1'b0, 3'b001});
        far.level(1'b0, 1'b0, 1'b0);
        rc(OFS_LINK, 32'h8);
        wr(OFS_STS, 32'h4);
        rc(OFS_STS, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        give_verdict();
    end
endmodule

// ---- tb/usbps_far_end.sv ----
`timescale 1ns/1ps
module usbps_far_end (
    // Clock
    input  wire logic             core_clk_i,
    // Bus state toward the controller
    output usbps_pkg::usbps_link_in_t link_o
);
    import usbps_pkg::*;

    usbps_link_in_t lk_q = '0;

    assign link_o = lk_q;

    ////////////////////////////////////////////////////////////////////////////
    // Line state only moves just after an edge, as the real bus does
    task level(input logic port_suspend, input logic att, input logic ovr);
        @(posedge core_clk_i);
        lk_q.host_suspend <= port_suspend;
        lk_q.dev_attached <= att;
        lk_q.rx_overrun   <= ovr;
    endtask

    // Single-cycle events: every high cycle acts, so keep them short
    task resume();
        @(posedge core_clk_i);
        lk_q.host_resume <= 1'b1;
        @(posedge core_clk_i);
        lk_q.host_resume <= 1'b0;
    endtask

    task wake();
        @(posedge core_clk_i);
        lk_q.remote_wake <= 1'b1;
        @(posedge core_clk_i);
        lk_q.remote_wake <= 1'b0;
    endtask
endmodule
